// File: osc_clk_params.svh
`ifndef OSC_CLK_PARAMS_SVH
`define OSC_CLK_PARAMS_SVH

// Core clock rate and derived timing
`define CORE_CLK_MHZ 125
`define INT_OSC_ACC_NS 8000
`define INT_OSC_ACC_CYC ((`INT_OSC_ACC_NS * `CORE_CLK_MHZ + 999) / 1000)

// Register byte addresses
`define ADDR_PROC_CLK_CTRL 8'h00
`define ADDR_MAIN_CLK_MODE 8'h04
`define ADDR_INT_OSC_MODE 8'h08
`define ADDR_MAIN_OSC_CTRL 8'h0c
`define ADDR_OSC_MODE_SEL 8'h10
`define ADDR_STAB_TIME_SEL 8'h14

// Processor clock control fields
`define PCC_DIV_LSB 0
`define PCC_DIV_MSB 2
`define PCC_CSS_BIT 4
`define PCC_CLS_BIT 5
`define PCC_START_BIT 6

// Main clock mode fields
`define MCM_MODE_BIT 0
`define MCM_MCS_BIT 1
`define MCM_EXTERNAL_MAIN_SELECT_BIT_BIT 2

// Internal oscillator mode fields
`define RCM_STOP_BIT 0
`define RCM_STABLE_BIT 7

// Main oscillator control field
`define MOC_STOP_BIT 7

// Oscillator mode select fields
`define OSC_SUBSEL_BIT 4
`define OSC_SUBEXT_BIT 5
`define OSC_MAINSEL_BIT 6
`define OSC_MAINEXT_BIT 7

// Stabilization time select field
`define STABILIZATION_TIME_SELECT_MSB 2

// Reset values and divider encodings
`define DIV_RESET 3'h1
`define DIV_MAX_CODE 3'h4
`define MAIN_STOP_RESET 1'b1

`endif

// File: osc_clk_pkg.sv
package osc_clk_pkg;

    // Which oscillator feeds a clock
    typedef enum logic [1:0] {
        SRC_INT = 2'b00,
        SRC_HS = 2'b01,
        SRC_SUB = 2'b10
    } clk_src_e;

    // Use of a pair of oscillator pins
    typedef enum logic [1:0] {
        PIN_PORT = 2'b00,
        PIN_OSC = 2'b01,
        PIN_EXT = 2'b10
    } pin_mode_e;

endpackage

// File: osc_sync2.sv
`timescale 1ns/100ps

module osc_sync2 #(
    parameter int W = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] asyncIn,
    output logic [W-1:0] syncOut
);

    // Two stages per bit; only the second is visible
    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // Per-bit stage chaining
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_comb begin
                next_st.stage1[i] = asyncIn[i];
                next_st.stage2[i] = st.stage1[i];
            end
        end
    endgenerate

    // Registered copy of the state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.stage2;

endmodule

// File: osc_stable_timer.sv
`timescale 1ns/100ps

module osc_stable_timer #(
    parameter int CYCLES = 1000
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic run,
    output logic done
);

    localparam int CW = $clog2(CYCLES + 1);

    // Elapsed time and the accuracy flag
    typedef struct packed {
        logic [CW-1:0] cnt;
        logic done;
    } tmr_s;

    tmr_s st;
    tmr_s next_st;

    // Restart whenever the oscillator is stopped
    always_comb begin
        next_st = st;
        if (!run) begin
            next_st.cnt = '0;
            next_st.done = 1'b0;
        end else if (st.cnt == CW'(CYCLES - 1)) begin
            next_st.done = 1'b1;
        end else begin
            next_st.cnt = st.cnt + CW'(1);
        end
    end

    // Registered copy of the state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign done = st.done;

endmodule

// File: osc_clk_ctrl.sv
// Overview of operation
// - Stop standby halts main oscillator and input
// - Stop standby halts internal high-speed oscillator
// - Main stop bit one halts main source
// - Two flags report current CPU source
// - Internal stop bit zero starts oscillator
// - Accuracy flag rises once oscillator settles
// - After reset internal oscillator runs, feeds CPU
// - External-select picks peripheral and main sources
// - Source select zero: CPU from main
// - Divider codes give 1 to 16
// - Internal stop bit one halts oscillator
// - Subsystem pins are ports after reset
// - Unused subsystem pins stay ordinary ports
// - Start bit or select enables crystal mode
// - Select plus external bit: external input
// - Source select one: subsystem divided by two
// - Both bits one: high-speed clock everywhere
`timescale 1ns/100ps
`include "osc_clk_params.svh"

module osc_clk_ctrl import osc_clk_pkg::*; (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regRdata,
    input wire logic stopCmd,
    input wire logic wakeReq,
    input wire logic intOscClk,
    input wire logic mainOscClk,
    input wire logic subOscClk,
    output logic cpuClkTick,
    output logic periphClkTick,
    output logic cpuOnSubsystem,
    output logic mainSourceStatus,
    output logic intOscEnable,
    output logic mainOscEnable,
    output logic subOscEnable,
    output logic [1:0] mainPinMode,
    output logic [1:0] subPinMode,
    output logic [2:0] stabTimeSel,
    output logic stopActive,
    output logic intOscStable
);

    // Whole state of the controller
    typedef struct packed {
        logic [2:0] divCode;      // Divider field as written
        logic cpuSrcSel;          // CPU source select
        logic subStart;           // Subsystem start
        logic extSel;             // External main select
        logic mainMode;           // Main mode
        logic intOscStop;         // Internal oscillator stop
        logic mainOscStop;        // Main oscillator stop
        logic mainExtClk;         // Main pins take external clock
        logic mainPinSel;         // Main pins used for a clock
        logic subExtClk;          // Subsystem pins take external clock
        logic subPinSel;          // Subsystem pins used for a clock
        logic [2:0] stabTime;     // Stabilization time select
        logic stopMode;           // Stop standby active
        logic [2:0] oscPrev;      // Last synced oscillator levels
        clk_src_e cpuSrc;         // Source now driving the CPU
        logic [2:0] activeDiv;    // Divider now in use
        logic mainFlag;           // Main source status
        logic [3:0] cnt;          // CPU divider count
        logic cpuTick;            // CPU clock pulse
        clk_src_e perSrc;         // Source now driving peripherals
        logic perTick;            // Peripheral clock pulse
        logic [7:0] rdata;        // Read data
        logic mainOscEn;          // Main oscillator enable
        logic intOscEn;           // Internal oscillator enable
        logic subOscEn;           // Subsystem oscillator enable
        pin_mode_e mainPins;      // Main pin mode
        pin_mode_e subPins;       // Subsystem pin mode
    } ctrl_s;

    ctrl_s st;
    ctrl_s next_st;
    logic [2:0] oscSync;          // Oscillator levels in core domain
    logic stableFlag;             // Internal oscillator accurate

    // Oscillator outputs arrive asynchronously
    osc_sync2 #(
        .W(3)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .asyncIn({subOscClk, mainOscClk, intOscClk}),
        .syncOut(oscSync)
    );

    // Accuracy timer restarts with each oscillator start
    osc_stable_timer #(
        .CYCLES(`INT_OSC_ACC_CYC)
    ) u_stable (
        .core_clk(core_clk),
        .rst(rst),
        .run(st.intOscEn),
        .done(stableFlag)
    );

    // Count limit for one CPU clock period
    function automatic logic [3:0] divLimit(input clk_src_e s, input logic [2:0] d);
        logic [3:0] lim;
        lim = 4'h0;
        if (s == SRC_SUB) begin
            lim = 4'h1;
        end else begin
            case (d)
                3'h0: lim = 4'h0;
                3'h1: lim = 4'h1;
                3'h2: lim = 4'h3;
                3'h3: lim = 4'h7;
                default: lim = 4'hf;
            endcase
        end
        return lim;
    endfunction

    // Next-state logic
    always_comb begin
        logic [2:0] srcTick;
        logic [2:0] srcAlive;
        logic mainHs;
        clk_src_e cpuTarget;
        clk_src_e perTarget;
        logic cpuEdge;
        logic cpuAlive;
        logic perEdge;
        logic perAlive;
        logic [7:0] rv;
        srcTick = oscSync & ~st.oscPrev;
        srcAlive = {st.subOscEn, st.mainOscEn, st.intOscEn};
        mainHs = st.extSel && st.mainMode;
        cpuTarget = SRC_INT;
        perTarget = SRC_INT;
        cpuEdge = 1'b0;
        cpuAlive = 1'b0;
        perEdge = 1'b0;
        perAlive = 1'b0;
        rv = 8'h00;
        next_st = st;
        next_st.cpuTick = 1'b0;
        next_st.perTick = 1'b0;
        next_st.rdata = 8'h00;
        next_st.oscPrev = oscSync;

        // Register writes
        if (regWrite) begin
            if (regAddr == `ADDR_PROC_CLK_CTRL) begin
                next_st.divCode = regWdata[`PCC_DIV_MSB:`PCC_DIV_LSB];
                next_st.cpuSrcSel = regWdata[`PCC_CSS_BIT];
                next_st.subStart = regWdata[`PCC_START_BIT];
            end else if (regAddr == `ADDR_MAIN_CLK_MODE) begin
                next_st.extSel = regWdata[`MCM_EXTERNAL_MAIN_SELECT_BIT_BIT];
                next_st.mainMode = regWdata[`MCM_MODE_BIT];
            end else if (regAddr == `ADDR_INT_OSC_MODE) begin
                next_st.intOscStop = regWdata[`RCM_STOP_BIT];
            end else if (regAddr == `ADDR_MAIN_OSC_CTRL) begin
                next_st.mainOscStop = regWdata[`MOC_STOP_BIT];
            end else if (regAddr == `ADDR_OSC_MODE_SEL) begin
                next_st.mainExtClk = regWdata[`OSC_MAINEXT_BIT];
                next_st.mainPinSel = regWdata[`OSC_MAINSEL_BIT];
                next_st.subExtClk = regWdata[`OSC_SUBEXT_BIT];
                next_st.subPinSel = regWdata[`OSC_SUBSEL_BIT];
            end else if (regAddr == `ADDR_STAB_TIME_SEL) begin
                next_st.stabTime = regWdata[`STABILIZATION_TIME_SELECT_MSB:0];
            end
        end

        // Stop standby; entry wins over a coincident wake
        if (stopCmd) begin
            next_st.stopMode = 1'b1;
        end else if (wakeReq) begin
            next_st.stopMode = 1'b0;
        end
        // Main pin mode
        if (!next_st.mainPinSel) begin
            next_st.mainPins = PIN_PORT;
        end else if (next_st.mainExtClk) begin
            next_st.mainPins = PIN_EXT;
        end else begin
            next_st.mainPins = PIN_OSC;
        end
        // Subsystem pin mode; start bit overrides the others
        if (next_st.subStart) begin
            next_st.subPins = PIN_OSC;
        end else if (!next_st.subPinSel) begin
            next_st.subPins = PIN_PORT;
        end else if (next_st.subExtClk) begin
            next_st.subPins = PIN_EXT;
        end else begin
            next_st.subPins = PIN_OSC;
        end
        // Oscillator enables; subsystem keeps running in stop
        next_st.mainOscEn = (next_st.mainPins != PIN_PORT) && !next_st.mainOscStop
            && !next_st.stopMode;
        next_st.intOscEn = !next_st.intOscStop && !next_st.stopMode;
        next_st.subOscEn = next_st.subPins != PIN_PORT;
        // Wanted sources
        if (st.cpuSrcSel) begin
            cpuTarget = SRC_SUB;
        end else if (mainHs) begin
            cpuTarget = SRC_HS;
        end else begin
            cpuTarget = SRC_INT;
        end
        perTarget = st.extSel ? SRC_HS : SRC_INT;
        // Edges of the sources in use
        case (st.cpuSrc)
            SRC_HS: begin
                cpuEdge = srcTick[1];
                cpuAlive = srcAlive[1];
            end
            SRC_SUB: begin
                cpuEdge = srcTick[2];
                cpuAlive = srcAlive[2];
            end
            default: begin
                cpuEdge = srcTick[0];
                cpuAlive = srcAlive[0];
            end
        endcase
        perEdge = (st.perSrc == SRC_HS) ? srcTick[1] : srcTick[0];
        perAlive = (st.perSrc == SRC_HS) ? srcAlive[1] : srcAlive[0];

        // CPU clock; changes land at a period boundary, or at once when the source is dead
        if (cpuEdge) begin
            if (st.cnt >= divLimit(st.cpuSrc, st.activeDiv)) begin
                next_st.cpuTick = 1'b1;
                next_st.cnt = 4'h0;
                next_st.cpuSrc = cpuTarget;
                next_st.mainFlag = mainHs;
                if (st.divCode <= `DIV_MAX_CODE) begin
                    next_st.activeDiv = st.divCode;
                end
            end else begin
                next_st.cnt = st.cnt + 4'h1;
            end
        end else if (!cpuAlive && cpuTarget != st.cpuSrc) begin
            // A dead source gives no boundary, so no pulse can be cut
            next_st.cnt = 4'h0;
            next_st.cpuSrc = cpuTarget;
            next_st.mainFlag = mainHs;
        end
        // Peripheral clock follows its source edge for edge
        if (perEdge) begin
            next_st.perTick = 1'b1;
            next_st.perSrc = perTarget;
        end else if (!perAlive) begin
            next_st.perSrc = perTarget;
        end

        // Register reads; unmapped addresses read zero
        if (regRead) begin
            if (regAddr == `ADDR_PROC_CLK_CTRL) begin
                rv[`PCC_DIV_MSB:`PCC_DIV_LSB] = st.divCode;
                rv[`PCC_CSS_BIT] = st.cpuSrcSel;
                rv[`PCC_CLS_BIT] = st.cpuSrc == SRC_SUB;
                rv[`PCC_START_BIT] = st.subStart;
            end else if (regAddr == `ADDR_MAIN_CLK_MODE) begin
                rv[`MCM_EXTERNAL_MAIN_SELECT_BIT_BIT] = st.extSel;
                rv[`MCM_MCS_BIT] = st.mainFlag;
                rv[`MCM_MODE_BIT] = st.mainMode;
            end else if (regAddr == `ADDR_INT_OSC_MODE) begin
                rv[`RCM_STOP_BIT] = st.intOscStop;
                rv[`RCM_STABLE_BIT] = stableFlag;
            end else if (regAddr == `ADDR_MAIN_OSC_CTRL) begin
                rv[`MOC_STOP_BIT] = st.mainOscStop;
            end else if (regAddr == `ADDR_OSC_MODE_SEL) begin
                rv[`OSC_MAINEXT_BIT] = st.mainExtClk;
                rv[`OSC_MAINSEL_BIT] = st.mainPinSel;
                rv[`OSC_SUBEXT_BIT] = st.subExtClk;
                rv[`OSC_SUBSEL_BIT] = st.subPinSel;
            end else if (regAddr == `ADDR_STAB_TIME_SEL) begin
                rv[`STABILIZATION_TIME_SELECT_MSB:0] = st.stabTime;
            end
            next_st.rdata = rv;
        end
    end

    // State register; reset leaves CPU on the internal oscillator
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
            st.divCode <= `DIV_RESET;
            st.activeDiv <= `DIV_RESET;
            st.mainOscStop <= `MAIN_STOP_RESET;
            st.intOscEn <= 1'b1;
            st.cpuSrc <= SRC_INT;
            st.perSrc <= SRC_INT;
            st.mainPins <= PIN_PORT;
            st.subPins <= PIN_PORT;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register and the accuracy timer flag
    assign regRdata = st.rdata;
    assign cpuClkTick = st.cpuTick;
    assign periphClkTick = st.perTick;
    assign cpuOnSubsystem = st.cpuSrc == SRC_SUB;
    assign mainSourceStatus = st.mainFlag;
    assign intOscEnable = st.intOscEn;
    assign mainOscEnable = st.mainOscEn;
    assign subOscEnable = st.subOscEn;
    assign mainPinMode = st.mainPins;
    assign subPinMode = st.subPins;
    assign stabTimeSel = st.stabTime;
    assign stopActive = st.stopMode;
    assign intOscStable = stableFlag;

    // Checks on the design's own behaviour
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_stop_main_off: assert property (stopCmd |=> !mainOscEnable && stopActive)
        else $error("main source running in stop");
    chk_stop_int_off: assert property (stopCmd |=> !intOscEnable ##1 !intOscStable)
        else $error("internal oscillator running in stop");
    chk_main_stop_bit: assert property (regWrite && regAddr == `ADDR_MAIN_OSC_CTRL
        && regWdata[`MOC_STOP_BIT] |=> !mainOscEnable)
        else $error("main stop bit ignored");
    chk_cls_readback: assert property (regRead && regAddr == `ADDR_PROC_CLK_CTRL
        |=> regRdata[`PCC_CLS_BIT] == $past(cpuOnSubsystem))
        else $error("subsystem flag read wrong");
    chk_int_start: assert property (regWrite && regAddr == `ADDR_INT_OSC_MODE
        && !regWdata[`RCM_STOP_BIT] && !stopCmd && !stopActive |=> intOscEnable)
        else $error("internal oscillator did not start");
    chk_int_halt: assert property (regWrite && regAddr == `ADDR_INT_OSC_MODE
        && regWdata[`RCM_STOP_BIT] |=> !intOscEnable ##1 !intOscStable)
        else $error("internal oscillator did not halt");
    chk_stable_restart: assert property ($rose(intOscEnable) |-> !intOscStable [*2])
        else $error("accuracy flag early");
    chk_reset_state: assert property ($past(rst) |-> intOscEnable && !cpuOnSubsystem
        && !mainSourceStatus && mainPinMode == PIN_PORT && subPinMode == PIN_PORT)
        else $error("wrong state after reset");
    chk_sub_start: assert property (regWrite && regAddr == `ADDR_PROC_CLK_CTRL
        && regWdata[`PCC_START_BIT] |=> subPinMode == PIN_OSC)
        else $error("start bit did not force crystal mode");
    chk_sub_ext: assert property (regWrite && regAddr == `ADDR_OSC_MODE_SEL
        && regWdata[`OSC_SUBEXT_BIT] && regWdata[`OSC_SUBSEL_BIT] && !st.subStart
        |=> subPinMode == PIN_EXT)
        else $error("subsystem external mode not taken");
    chk_sub_half: assert property (oscSync[2] && !st.oscPrev[2] && st.cpuSrc == SRC_SUB
        && st.cnt == 4'h0 |=> !cpuClkTick)
        else $error("subsystem CPU clock not halved");
    chk_switch_edge: assert property ($changed(st.cpuSrc) |-> cpuClkTick
        || !$past(st.mainOscEn) || !$past(st.intOscEn) || !$past(st.subOscEn))
        else $error("CPU source changed mid period");
    cov_on_sub: cover property ($rose(cpuOnSubsystem));
    cov_on_hs: cover property ($rose(mainSourceStatus) && !cpuOnSubsystem);
    cov_stop_wake: cover property (stopActive ##1 !stopActive);
    cov_stable: cover property ($rose(intOscStable));

endmodule

// File: osc_source_model.sv
`timescale 1ns/100ps

module osc_source_model (
    input wire logic intOscEnable,
    input wire logic mainOscEnable,
    input wire logic subOscEnable,
    output logic intOscClk,
    output logic mainOscClk,
    output logic subOscClk
);
    // Internal oscillator, 40 ns period, still while disabled
    initial begin
        intOscClk = 1'b0;
        #2;
        forever #20 intOscClk = intOscEnable ? ~intOscClk : 1'b0;
    end

    // Main crystal, 56 ns period; offset keeps edges off the core edge
    initial begin
        mainOscClk = 1'b0;
        #2;
        forever #28 mainOscClk = mainOscEnable ? ~mainOscClk : 1'b0;
    end

    // Subsystem crystal, 200 ns period, no output until pins leave port mode
    initial begin
        subOscClk = 1'b0;
        #2;
        forever #100 subOscClk = subOscEnable ? ~subOscClk : 1'b0;
    end
endmodule

// File: testbench.sv
`timescale 1ns/100ps

module testbench import osc_clk_pkg::*;;
    logic core_clk, rst, regWrite, regRead, stopCmd, wakeReq;
    logic [7:0] regAddr, regWdata, regRdata, rdVal;
    logic intOscClk, mainOscClk, subOscClk, cpuClkTick, periphClkTick;
    logic cpuOnSubsystem, mainSourceStatus, intOscEnable, mainOscEnable, subOscEnable;
    logic [1:0] mainPinMode, subPinMode;
    logic [2:0] stabTimeSel;
    logic stopActive, intOscStable;
    logic [15:0] gapLen;
    logic [1:0] subExp [5] = '{2'b01, 2'b00, 2'b01, 2'b10, 2'b00};
    logic [2:0] subCfg [5] = '{3'b100, 3'b000, 3'b001, 3'b011, 3'b010};
    int err_total = 0;
    int checks_done = 0;

    osc_clk_ctrl osc_clk_ctrl_i (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .stopCmd(stopCmd), .wakeReq(wakeReq), .intOscClk(intOscClk), .mainOscClk(mainOscClk),
        .subOscClk(subOscClk), .cpuClkTick(cpuClkTick), .periphClkTick(periphClkTick),
        .cpuOnSubsystem(cpuOnSubsystem), .mainSourceStatus(mainSourceStatus),
        .intOscEnable(intOscEnable), .mainOscEnable(mainOscEnable),
        .subOscEnable(subOscEnable), .mainPinMode(mainPinMode), .subPinMode(subPinMode),
        .stabTimeSel(stabTimeSel), .stopActive(stopActive), .intOscStable(intOscStable));

    osc_source_model osc_source_model_i (.intOscEnable(intOscEnable),
        .mainOscEnable(mainOscEnable), .subOscEnable(subOscEnable),
        .intOscClk(intOscClk), .mainOscClk(mainOscClk), .subOscClk(subOscClk));

    // Core clock, 8 ns period
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1 d = regRdata;
    endtask

    // Let a control write land before looking at the levels
    task automatic settle();
        @(posedge core_clk);
        #1;
    endtask

    // Cycles between two ticks; bounded so a dead clock shows as a large gap
    task automatic gap(input bit periph, output logic [15:0] n);
        int k;
        n = 16'hffff;
        for (k = 0; k < 300; k++) begin
            @(posedge core_clk);
            #1;
            if (periph ? periphClkTick : cpuClkTick) break;
        end
        for (k = 1; k < 300; k++) begin
            @(posedge core_clk);
            #1;
            if (periph ? periphClkTick : cpuClkTick) begin
                n = 16'(k);
                break;
            end
        end
    endtask

    // Pulse a standby request for one cycle
    task automatic pulse(input bit wake);
        @(posedge core_clk);
        if (wake) wakeReq <= 1'b1;
        else stopCmd <= 1'b1;
        @(posedge core_clk);
        wakeReq <= 1'b0;
        stopCmd <= 1'b0;
        settle();
    endtask

    // Verdict in one place
    task automatic test_done();
        $display("checks %0d, errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #200000;
        err_total++;
        test_done();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        regAddr = 8'h00;
        regWdata = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        stopCmd = 1'b0;
        wakeReq = 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk("intOscEnable", 1, intOscEnable);
        chk("cpuOnSubsystem", 0, cpuOnSubsystem);
        chk("mainSourceStatus", 0, mainSourceStatus);
        chk("subPinMode", 2'b00, subPinMode);
        chk("intOscStable", 0, intOscStable);
        rd(8'h00, rdVal);
        chk("proc clk ctrl", 8'h01, rdVal);
        rd(8'h0c, rdVal);
        chk("main osc ctrl", 8'h80, rdVal);
        // Every legal divider on the internal oscillator, 5 cycles per edge
        for (int c = 0; c < 5; c++) begin
            wr(8'h00, 8'(c));
            gap(0, gapLen);
            gap(0, gapLen);
            chk("cpu gap", 16'(5 << c), gapLen);
        end
        gap(1, gapLen);
        chk("periph gap int", 16'd5, gapLen);
        // Start the main crystal
        wr(8'h10, 8'h40);
        wr(8'h0c, 8'h00);
        settle();
        chk("mainOscEnable", 1, mainOscEnable);
        chk("mainPinMode", 2'b01, mainPinMode);
        wr(8'h04, 8'h04);
        gap(1, gapLen);
        gap(1, gapLen);
        chk("periph gap hs", 16'd7, gapLen);
        chk("mainSourceStatus", 0, mainSourceStatus);
        wr(8'h04, 8'h05);
        gap(0, gapLen);
        gap(0, gapLen);
        chk("cpu gap hs", 16'd112, gapLen);
        chk("mainSourceStatus", 1, mainSourceStatus);
        gap(1, gapLen);
        chk("periph gap hs", 16'd7, gapLen);
        // CPU is off the internal oscillator, so it may be stopped
        wr(8'h08, 8'h01);
        settle();
        chk("intOscEnable", 0, intOscEnable);
        wr(8'h08, 8'h00);
        settle();
        chk("intOscEnable", 1, intOscEnable);
        // Stabilization time is set before stop
        wr(8'h14, 8'h05);
        settle();
        chk("stabTimeSel", 3'h5, stabTimeSel);
        rd(8'h14, rdVal);
        chk("stab time", 8'h05, rdVal);
        pulse(0);
        chk("stopActive", 1, stopActive);
        chk("mainOscEnable", 0, mainOscEnable);
        chk("intOscEnable", 0, intOscEnable);
        pulse(1);
        settle();
        chk("stopActive", 0, stopActive);
        chk("mainOscEnable", 1, mainOscEnable);
        chk("intOscEnable", 1, intOscEnable);
        // Subsystem crystal feeds the CPU at half rate, whatever the divider
        wr(8'h10, 8'h50);
        repeat (60) @(posedge core_clk);
        wr(8'h00, 8'h14);
        gap(0, gapLen);
        gap(0, gapLen);
        chk("cpu gap sub", 16'd50, gapLen);
        chk("cpuOnSubsystem", 1, cpuOnSubsystem);
        wr(8'h04, 8'h00);
        wr(8'h00, 8'h01);
        gap(0, gapLen);
        gap(0, gapLen);
        chk("cpuOnSubsystem", 0, cpuOnSubsystem);
        chk("mainSourceStatus", 0, mainSourceStatus);
        chk("cpu gap int", 16'd10, gapLen);
        wr(8'h0c, 8'h80);
        settle();
        chk("mainOscEnable", 0, mainOscEnable);
        // Subsystem pin modes from start, external and select bits
        for (int i = 0; i < 5; i++) begin
            wr(8'h10, {2'b01, subCfg[i][1:0], 4'h0});
            wr(8'h00, {1'b0, subCfg[i][2], 6'h01});
            settle();
            chk("subPinMode", 16'(subExp[i]), 16'(subPinMode));
            chk("subOscEnable", 16'(subExp[i] != 2'b00), 16'(subOscEnable));
        end
        rd(8'h20, rdVal);
        chk("unmapped read", 8'h00, rdVal);
        repeat (1010) @(posedge core_clk);
        #1;
        chk("intOscStable", 1, intOscStable);
        rd(8'h08, rdVal);
        chk("int osc mode", 8'h80, rdVal);
        test_done();
    end
endmodule
